//--- rsl_pkg.sv
/*
 * Constants and carriers for the reset strap loader.
 * Assumes a 28-bit external address bus and a 100 MHz system clock.
 */
package rsl_pkg;

    // Strap positions on the external address bus
    localparam int ADDR_W = 28;
    localparam int ENDIAN_BIT = 27;
    localparam int CPU_BIT = 26;
    localparam int CS0_HI = 24;
    localparam int CS0_LO = 23;
    localparam int IDENT_HI = 19;
    localparam int IDENT_LO = 9;
    localparam int PRESCALE_HI = 8;
    localparam int PRESCALE_LO = 7;
    localparam int OUTSEL_HI = 6;
    localparam int OUTSEL_LO = 5;
    localparam int FBDIV_HI = 4;
    localparam int FBDIV_LO = 0;

    // Reset path depth; the pin synchronisers are a fixed two stages
    localparam int RESET_STAGES = 3;

    // Values loaded before the first sample
    localparam logic ENDIAN_DEFAULT = 1'h0;
    localparam logic CPU_DEFAULT = 1'h1;
    localparam logic [1:0] CS0_DEFAULT = 2'h2;
    localparam logic [10:0] IDENT_DEFAULT = 11'h3FF;
    localparam logic [1:0] PRESCALE_DEFAULT = 2'h2;
    localparam logic [1:0] OUTSEL_DEFAULT = 2'h0;
    localparam logic [4:0] FBDIV_DEFAULT = 5'h0B;

    // Chip-select-0 port codes and wait states
    localparam logic [1:0] CS0_8BIT_SLOW = 2'h0;
    localparam logic [1:0] CS0_32BIT_SLOW = 2'h1;
    localparam logic [1:0] CS0_32BIT = 2'h2;
    localparam logic [1:0] CS0_16BIT_SLOW = 2'h3;
    localparam logic [5:0] CS0_WAIT_MAX = 6'h3F;
    localparam logic [5:0] CS0_WAIT_NONE = 6'h00;

    // Mode pin code that hands the test pins to the debug port
    localparam logic [2:0] DEBUG_MODE_CODE = 3'h3;

    // Register offsets
    localparam logic [3:0] REG_BOOT = 4'h0;
    localparam logic [3:0] REG_PLL = 4'h4;
    localparam logic [3:0] REG_IDENT = 4'h8;
    localparam logic [3:0] REG_MODE = 4'hC;

    typedef enum logic [1:0] {RSL_W8, RSL_W16, RSL_W32} rsl_width_t;

    typedef struct packed {
        logic big_endian;
        logic cpu_enable;
        logic [1:0] chip_select_zero_cfg;
        logic [10:0] system_identity_field;
        logic [1:0] pll_prescale_select;
        logic [1:0] pll_output_select;
        logic [4:0] pll_feedback_divider;
    } rsl_strap_t;

    typedef struct packed {
        rsl_width_t width;
        logic [5:0] wait_states;
    } rsl_cs0_t;

    localparam rsl_strap_t STRAP_DEFAULT = '{ENDIAN_DEFAULT, CPU_DEFAULT,
        CS0_DEFAULT, IDENT_DEFAULT, PRESCALE_DEFAULT, OUTSEL_DEFAULT, FBDIV_DEFAULT};

endpackage : rsl_pkg

//--- rsl_top.sv
/*
 * Reset strap loader: synchronises the chip reset, samples the address
 * straps while reset is held, holds them afterwards, decodes the
 * chip-select-0 port setup and routes the shared test port.
 * Assumes board straps on the address pins and reset held three clocks.
 */
`timescale 1ns/100ps

module rsl_top
    import rsl_pkg::*;
(
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic resetn, // Chip reset pin, active low
    input wire logic [rsl_pkg::ADDR_W-1:0] addr_pin, // Address bus pins
    input wire logic chip_mode_pin_a_n, // Chip mode pin a
    input wire logic self_test_pin_n, // Chip mode pin b
    input wire logic scan_mode_pin_n, // Chip mode pin c
    input wire logic dbg_tdo, // Debug port data out
    input wire logic dbg_tdo_en, // Debug port drive enable
    input wire logic bscan_tdo, // Boundary scan data out
    input wire logic bscan_tdo_en, // Boundary scan drive enable
    input wire logic [3:0] reg_addr, // Register offset
    input wire logic [31:0] reg_wdata, // Write data, ignored
    input wire logic reg_wr, // Write strobe, ignored
    input wire logic reg_rd, // Read strobe
    output logic [31:0] reg_rdata, // Read data, cycle after strobe
    output rsl_pkg::rsl_strap_t strap_cfg, // Captured straps
    output logic bus_error_flag, // Set while core held off
    output rsl_pkg::rsl_cs0_t cs0_port, // Decoded port setup
    output logic chip_reset_active, // Internal reset level
    output logic debug_tap_sel, // Test pins go to debug port
    output logic tdo_out, // Test data out pin value
    output logic tdo_oe // Test data out drive enable
);
    import rsl_pkg::*;

    typedef enum logic [1:0] {RSL_HOLD, RSL_PRIME, RSL_SAMPLE} rsl_state_t;

    logic [RESET_STAGES-1:0] rst_sync_ff;
    logic [RESET_STAGES-1:0] nxt_rst_sync;
    logic [ADDR_W-1:0] addr_s1_ff;
    logic [ADDR_W-1:0] addr_s2_ff;
    logic [2:0] mode_s1_ff;
    logic [2:0] mode_s2_ff;
    logic dbg_sel_ff;
    logic nxt_dbg_sel;
    rsl_state_t state_ff;
    rsl_state_t nxt_state;
    rsl_strap_t strap_ff;
    rsl_strap_t nxt_strap;
    rsl_strap_t sampled;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic in_reset;

    // Chip-select-0 code to port width and wait states
    function automatic rsl_cs0_t cs0_decode(input logic [1:0] code);
        rsl_cs0_t d;
        d.width = RSL_W32;
        d.wait_states = CS0_WAIT_NONE;
        case (code)
            CS0_8BIT_SLOW: begin
                d.width = RSL_W8;
                d.wait_states = CS0_WAIT_MAX;
            end
            CS0_32BIT_SLOW: begin
                d.wait_states = CS0_WAIT_MAX;
            end
            CS0_16BIT_SLOW: begin
                d.width = RSL_W16;
                d.wait_states = CS0_WAIT_MAX;
            end
            default: begin
                d.width = RSL_W32;
            end
        endcase
        return d;
    endfunction : cs0_decode

    // Reset shift chain; it carries the reset itself, so it has none
    always_comb begin
        nxt_rst_sync = {rst_sync_ff[RESET_STAGES-2:0], resetn};
    end

    always_ff @(posedge clk_sys) begin
        rst_sync_ff <= nxt_rst_sync;
    end

    // Reset counts only after the third stage; short pulses may be missed
    assign in_reset = ~rst_sync_ff[RESET_STAGES-1];
    assign chip_reset_active = in_reset;

    // Pin synchronisers, free running so they are primed during reset
    always_ff @(posedge clk_sys) begin
        addr_s1_ff <= addr_pin;
        addr_s2_ff <= addr_s1_ff;
        mode_s1_ff <= {chip_mode_pin_a_n, self_test_pin_n, scan_mode_pin_n};
        mode_s2_ff <= mode_s1_ff;
    end

    // Strap fields cut out of the synchronised address
    always_comb begin
        sampled.big_endian = addr_s2_ff[ENDIAN_BIT];
        sampled.cpu_enable = addr_s2_ff[CPU_BIT];
        sampled.chip_select_zero_cfg = addr_s2_ff[CS0_HI:CS0_LO];
        sampled.system_identity_field = addr_s2_ff[IDENT_HI:IDENT_LO];
        sampled.pll_prescale_select = addr_s2_ff[PRESCALE_HI:PRESCALE_LO];
        sampled.pll_output_select = addr_s2_ff[OUTSEL_HI:OUTSEL_LO];
        sampled.pll_feedback_divider = addr_s2_ff[FBDIV_HI:FBDIV_LO];
    end

    // Loader: defaults on reset entry, then sample until release, then hold
    // Pins lag two clocks, so the last sample lands one clock after release
    always_comb begin
        nxt_state = state_ff;
        nxt_strap = strap_ff;
        case (state_ff)
            RSL_HOLD: begin
                if (in_reset) begin
                    nxt_state = RSL_PRIME;
                end
            end
            RSL_PRIME: begin
                nxt_strap = STRAP_DEFAULT;
                nxt_state = in_reset ? RSL_SAMPLE : RSL_HOLD;
            end
            RSL_SAMPLE: begin
                nxt_strap = sampled;
                nxt_state = in_reset ? RSL_SAMPLE : RSL_HOLD;
            end
            default: begin
                nxt_strap = STRAP_DEFAULT;
                nxt_state = RSL_PRIME;
            end
        endcase
    end

    // State comes from the reset chain itself, not from a reset branch
    always_ff @(posedge clk_sys) begin
        state_ff <= nxt_state;
        strap_ff <= nxt_strap;
    end

    assign strap_cfg = strap_ff;
    assign bus_error_flag = ~strap_ff.cpu_enable;
    assign cs0_port = cs0_decode(strap_ff.chip_select_zero_cfg);

    // Test port ownership follows the synchronised mode pins; forced off in reset
    always_comb begin
        nxt_dbg_sel = ~in_reset && (mode_s2_ff == DEBUG_MODE_CODE);
    end

    always_ff @(posedge clk_sys) begin
        dbg_sel_ff <= nxt_dbg_sel;
    end

    // Shared data-out pin; only one port ever reaches it
    assign debug_tap_sel = dbg_sel_ff;
    assign tdo_out = dbg_sel_ff ? dbg_tdo : bscan_tdo;
    assign tdo_oe = dbg_sel_ff ? dbg_tdo_en : bscan_tdo_en;

    // Read port; straps are read-only so writes are dropped
    // Reads during internal reset answer zero, like unmapped offsets
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (reg_rd && !in_reset) begin
            case (reg_addr)
                REG_BOOT: nxt_rdata = 32'({strap_ff.big_endian, strap_ff.cpu_enable,
                    bus_error_flag, strap_ff.chip_select_zero_cfg,
                    cs0_decode(strap_ff.chip_select_zero_cfg)});
                REG_PLL: nxt_rdata = 32'({strap_ff.pll_prescale_select,
                    strap_ff.pll_output_select, strap_ff.pll_feedback_divider});
                REG_IDENT: nxt_rdata = 32'(strap_ff.system_identity_field);
                REG_MODE: nxt_rdata = 32'({dbg_sel_ff, mode_s2_ff});
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        rdata_ff <= nxt_rdata;
    end

    assign reg_rdata = rdata_ff;

    // Checks
    sequence s_sampling;
        state_ff == RSL_SAMPLE;
    endsequence

    sequence s_long_low;
        $rose(resetn) && !$past(resetn, 2) && !$past(resetn, 3);
    endsequence

    // Reset entry: defaults first, sampling from the next cycle
    sequence s_reset_entry;
        state_ff == RSL_PRIME ##1 state_ff == RSL_SAMPLE;
    endsequence

    a_reset_chain: assert property (@(posedge clk_sys)
        s_long_low |-> in_reset [*3] ##1 !in_reset)
        else $error("reset chain depth wrong");

    a_endian_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_sampling |=> strap_ff.big_endian == $past(addr_s2_ff[ENDIAN_BIT]))
        else $error("endian strap not loaded");

    a_cpu_boot: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_sampling |=> strap_ff.cpu_enable == $past(addr_s2_ff[CPU_BIT])
            && bus_error_flag == !$past(addr_s2_ff[CPU_BIT]))
        else $error("core enable or bus error wrong");

    a_cs0_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_sampling |=> strap_ff.chip_select_zero_cfg == $past(addr_s2_ff[CS0_HI:CS0_LO]))
        else $error("chip select zero strap not loaded");

    a_cs0_slow8: assert property (@(posedge clk_sys) disable iff (!resetn)
        strap_ff.chip_select_zero_cfg == CS0_8BIT_SLOW
            |-> cs0_port.width == RSL_W8 && cs0_port.wait_states == 6'h3F)
        else $error("8-bit port decode wrong");

    // Remaining chip-select codes; the fast code must not pick up wait states
    a_cs0_slow16: assert property (@(posedge clk_sys) disable iff (!resetn)
        strap_ff.chip_select_zero_cfg == CS0_16BIT_SLOW
            |-> cs0_port.width == RSL_W16 && cs0_port.wait_states == 6'h3F)
        else $error("16-bit port decode wrong");

    a_cs0_slow32: assert property (@(posedge clk_sys) disable iff (!resetn)
        strap_ff.chip_select_zero_cfg == CS0_32BIT_SLOW
            |-> cs0_port.width == RSL_W32 && cs0_port.wait_states == 6'h3F)
        else $error("slow 32-bit port decode wrong");

    a_cs0_fast32: assert property (@(posedge clk_sys) disable iff (!resetn)
        strap_ff.chip_select_zero_cfg == CS0_32BIT
            |-> cs0_port.width == RSL_W32 && cs0_port.wait_states == 6'h00)
        else $error("fast 32-bit port decode wrong");

    a_ident_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_sampling |=> strap_ff.system_identity_field == $past(addr_s2_ff[IDENT_HI:IDENT_LO]))
        else $error("identity strap not loaded");

    a_prescale_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_sampling |=> strap_ff.pll_prescale_select == $past(addr_s2_ff[PRESCALE_HI:PRESCALE_LO]))
        else $error("prescale strap not loaded");

    a_outsel_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_sampling |=> strap_ff.pll_output_select == $past(addr_s2_ff[OUTSEL_HI:OUTSEL_LO]))
        else $error("output select strap not loaded");

    a_fbdiv_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_sampling |=> strap_ff.pll_feedback_divider == $past(addr_s2_ff[FBDIV_HI:FBDIV_LO]))
        else $error("feedback divider strap not loaded");

    a_prime_default: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_ff == RSL_PRIME |=> strap_ff.system_identity_field == 11'h3FF
            && strap_ff.pll_output_select == 2'h0
            && strap_ff.pll_prescale_select == 2'h2 && strap_ff.pll_feedback_divider == 5'h0B)
        else $error("defaults not loaded");

    a_strap_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        !in_reset && state_ff == RSL_HOLD |=> $stable(strap_ff) && state_ff == RSL_HOLD)
        else $error("straps changed outside reset");

    a_release_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(in_reset) |-> ##1 state_ff == RSL_HOLD ##1 $stable(strap_ff))
        else $error("loader did not stop at release");

    a_debug_sel: assert property (@(posedge clk_sys) disable iff (!resetn)
        !in_reset |=> debug_tap_sel == ($past(mode_s2_ff) == DEBUG_MODE_CODE))
        else $error("debug port selection wrong");

    a_tdo_route: assert property (@(posedge clk_sys) disable iff (!resetn)
        !debug_tap_sel |-> tdo_out == bscan_tdo && tdo_oe == bscan_tdo_en)
        else $error("test pin not with boundary scan");

    a_tdo_debug: assert property (@(posedge clk_sys) disable iff (!resetn)
        debug_tap_sel |-> tdo_out == dbg_tdo && tdo_oe == dbg_tdo_en)
        else $error("test pin not with debug port");

    a_debug_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
        in_reset |=> !debug_tap_sel && reg_rdata == 32'h0000_0000)
        else $error("debug port or read data live in reset");

    a_read_only_once: assert property (@(posedge clk_sys) disable iff (!resetn)
        !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside answer cycle");

    a_write_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_wr && !reg_rd && !in_reset && state_ff == RSL_HOLD
            |=> $stable(strap_ff) && reg_rdata == 32'h0000_0000)
        else $error("write disturbed straps or read data");

    a_reset_entry: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(in_reset) |=> s_reset_entry)
        else $error("loader did not prime then sample");

endmodule : rsl_top

//--- rsl_strap_board.sv
/*
 * Board side of the strap loader: pull resistors on the address bus.
 * Assumes the device drives the bus with traffic once it leaves reset.
 */
`timescale 1ns/100ps

module rsl_strap_board (
    input wire logic clk_sys, // System clock
    input wire logic chip_reset_active, // Device internal reset level
    input wire logic [rsl_pkg::ADDR_W-1:0] strap_val, // Fitted strap pattern
    output logic [rsl_pkg::ADDR_W-1:0] addr_pin // Bus level seen by the device
);
    import rsl_pkg::*;

    logic [1:0] idle_cnt_ff;
    logic [ADDR_W-1:0] noise_ff;

    // Straps held until three cycles after release, so the last sample sees them
    always_ff @(posedge clk_sys) begin
        if (chip_reset_active) begin
            idle_cnt_ff <= 2'h0;
        end else if (idle_cnt_ff != 2'h3) begin
            idle_cnt_ff <= idle_cnt_ff + 2'h1;
        end
        noise_ff <= ADDR_W'($urandom);
    end

    // Bus traffic afterwards is a new random pattern every cycle instead of the strap level
    assign addr_pin = (chip_reset_active || idle_cnt_ff != 2'h3) ? strap_val : noise_ff;
endmodule : rsl_strap_board

//--- rsl_top_test.sv
/*
 * Self-checking bench for the reset strap loader.
 * Assumes rsl_pkg, rsl_top and rsl_strap_board are compiled first.
 */
`timescale 1ns/100ps

module rsl_top_test;
    import rsl_pkg::*;

    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] strap_val = '0;
    logic [ADDR_W-1:0] addr_pin;
    logic [2:0] mode_pins = 3'h7;
    logic [3:0] tdo_src = 4'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    rsl_strap_t strap_cfg;
    logic bus_error_flag;
    rsl_cs0_t cs0_port;
    logic chip_reset_active;
    logic debug_tap_sel;
    logic tdo_out;
    logic tdo_oe;
    logic [31:0] rdat;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int exp_q[$];

    // 100 MHz system clock
    always #5 clk_sys = ~clk_sys;

    rsl_strap_board u_board (.clk_sys(clk_sys), .chip_reset_active(chip_reset_active), .strap_val(strap_val),
        .addr_pin(addr_pin));

    rsl_top u_dut (.clk_sys(clk_sys), .resetn(resetn), .addr_pin(addr_pin), .chip_mode_pin_a_n(mode_pins[2]),
        .self_test_pin_n(mode_pins[1]), .scan_mode_pin_n(mode_pins[0]), .dbg_tdo(tdo_src[3]),
        .dbg_tdo_en(tdo_src[2]), .bscan_tdo(tdo_src[1]), .bscan_tdo_en(tdo_src[0]), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .strap_cfg(strap_cfg),
        .bus_error_flag(bus_error_flag), .cs0_port(cs0_port), .chip_reset_active(chip_reset_active),
        .debug_tap_sel(debug_tap_sel), .tdo_out(tdo_out), .tdo_oe(tdo_oe));

    // Closing report, the single place the run ends
    task automatic results();
        $display("checks %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Writes are ignored, but must still be harmless
    task automatic wr(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= $urandom;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // Hold reset n cycles, then time the internal reset release
    task automatic do_reset(input int n);
        int k;
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (n) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        #1 chk("reset_level", 32'h1, chip_reset_active);
        k = 0;
        while (chip_reset_active !== 1'b0 && k < 8) begin
            @(posedge clk_sys);
            #1 k++;
        end
        chk("release_cycles", 32'(RESET_STAGES - 1), k);
    endtask : do_reset

    // Compare every field and register view with the fitted pattern
    task automatic check_straps(input logic [ADDR_W-1:0] a);
        logic [1:0] w;
        logic [5:0] ws;
        w = (a[24:23] == 2'h0) ? 2'h0 : (a[24:23] == 2'h3) ? 2'h1 : 2'h2;
        ws = (a[24:23] == 2'h2) ? 6'h00 : 6'h3F;
        exp_q.push_back(int'({a[27], a[26], ~a[26], a[24:23], w, ws}));
        exp_q.push_back(int'(a[8:0]));
        exp_q.push_back(int'(a[19:9]));
        chk("big_endian", a[27], strap_cfg.big_endian);
        chk("core_bus_error", {a[26], ~a[26]}, {strap_cfg.cpu_enable, bus_error_flag});
        chk("cs0_port", {a[24:23], w, ws}, {strap_cfg.chip_select_zero_cfg, cs0_port});
        chk("identity", a[19:9], strap_cfg.system_identity_field);
        chk("prescale", a[8:7], strap_cfg.pll_prescale_select);
        chk("output_sel", a[6:5], strap_cfg.pll_output_select);
        chk("fb_divider", a[4:0], strap_cfg.pll_feedback_divider);
        wr(REG_BOOT);
        rd(REG_BOOT, rdat);
        chk("reg_boot", exp_q.pop_front(), rdat);
        rd(REG_PLL, rdat);
        chk("reg_pll", exp_q.pop_front(), rdat);
        rd(REG_IDENT, rdat);
        chk("reg_ident", exp_q.pop_front(), rdat);
        rd(4'h2, rdat);
        chk("unmapped", 32'h0, rdat);
        @(posedge clk_sys);
        #1 chk("rdata_idle", 32'h0, reg_rdata);
    endtask : check_straps

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            results();
        end
    end

    initial begin
        logic [ADDR_W-1:0] a;
        logic sel;
        rdat = $urandom(97661);
        @(posedge clk_sys);
        // Each chip-select code twice; first pass uses the default identity and PLL strap levels
        for (int i = 0; i < 8; i++) begin
            a = ADDR_W'($urandom);
            a[24:23] = i[1:0];
            if (i == 0) begin
                a[19:0] = {11'h3FF, 2'h2, 2'h0, 5'h0B};
            end
            strap_val <= a;
            do_reset((i == 0) ? 6 : 3 + i % 4);
            repeat (2) @(posedge clk_sys);
            #1 check_straps(a);
            repeat (12) @(posedge clk_sys);
            #1 check_straps(a);
        end
        // Every mode pin code, with random data-out sources
        for (int m = 0; m < 8; m++) begin
            @(posedge clk_sys);
            mode_pins <= m[2:0];
            tdo_src <= 4'($urandom);
            repeat (4) @(posedge clk_sys);
            #1 sel = (mode_pins === DEBUG_MODE_CODE);
            chk("debug_tap_sel", sel, debug_tap_sel);
            chk("tdo_pin", sel ? tdo_src[3:2] : tdo_src[1:0], {tdo_out, tdo_oe});
            rd(REG_MODE, rdat);
            chk("reg_mode", {sel, m[2:0]}, rdat);
        end
        results();
    end
endmodule : rsl_top_test
